// File: design/qdl_pkg.sv
// Package of constants and carrier types for the quad converter loader
package qdl_pkg;
    localparam int CODE_W       = 12;
    localparam int WORD_W       = 16;
    localparam int CHANNELS     = 4;
    localparam int CNT_W        = 5;
    // Field positions in the command word
    localparam int ADDR_HI_POS  = 15;
    localparam int ADDR_LO_POS  = 14;
    localparam int CTRL_HI_POS  = 13;
    localparam int CTRL_LO_POS  = 12;
    // Control codes
    localparam logic [1:0] CTRL_SPECIAL = 2'h0;
    localparam logic [1:0] CTRL_LOAD_IN = 2'h1;
    localparam logic [1:0] CTRL_UPDATE  = 2'h2;
    localparam logic [1:0] CTRL_LOAD_UP = 2'h3;
    // Address codes of the edge selecting commands
    localparam logic [1:0] ADDR_EDGE_RISE = 2'h3;
    localparam logic [1:0] ADDR_EDGE_FALL = 2'h2;
    // Reset values
    localparam logic [WORD_W-1:0] SHIFT_RESET = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_RESET  = 12'h000;
    localparam logic              EDGE_RESET  = 1'b1;
    // Timing: serial clock ceiling and sampling clock
    localparam int SCLK_MAX_KHZ = 10000;
    localparam int CLK_KHZ      = 20000;

    // Decoded command carried from decoder to main block
    typedef struct packed {
        logic                 load_in;
        logic                 load_all_sr;
        logic                 upd_all;
        logic                 upd_one;
        logic                 set_edge;
        logic                 edge_rise;
        logic [1:0]           chan;
        logic [CODE_W-1:0]    code;
    } qdl_cmd_t;

    // Synchronised pin levels
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sin;
        logic load_n;
    } qdl_pins_t;
endpackage

// File: design/qdl_sync.sv
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ns
`default_nettype none
module qdl_sync
    import qdl_pkg::*;
(
    input  wire logic      clock,    // System clock
    input  wire logic      srst,     // Synchronous reset
    input  wire qdl_pins_t pins_in,  // Raw pin levels
    output qdl_pins_t      pins_out  // Synchronised levels
);
    typedef struct packed {
        qdl_pins_t s1;
        qdl_pins_t s2;
    } qdl_sync_st_t;

    localparam qdl_pins_t IDLE_PINS = '{cs_n: 1'b1, sclk: 1'b0,
                                        sin: 1'b0, load_n: 1'b1};

    qdl_sync_st_t st_r;
    qdl_sync_st_t st_nxt;

    // First stage feeds only the second stage
    always_comb begin
        st_nxt.s1 = pins_in;
        st_nxt.s2 = st_r.s1;
        if (srst) begin
            st_nxt.s1 = IDLE_PINS;
            st_nxt.s2 = IDLE_PINS;
        end
    end

    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    assign pins_out = st_r.s2;
endmodule
`default_nettype wire

// File: design/qdl_decode.sv
// Command decoder for the sixteen-bit word
`timescale 1ns/1ns
`default_nettype none
module qdl_decode
    import qdl_pkg::*;
(
    input  wire logic [WORD_W-1:0] word,    // Captured shift word
    input  wire logic              load_n,  // Load strobe level
    output qdl_cmd_t               cmd      // Decoded actions
);
    logic [1:0] addr;
    logic [1:0] ctrl;

    assign addr = {word[ADDR_HI_POS], word[ADDR_LO_POS]};
    assign ctrl = {word[CTRL_HI_POS], word[CTRL_LO_POS]};

    // Strobe low turns a control 01 or 11 load into a per-channel transparent load
    always_comb begin
        cmd             = '0;
        cmd.chan        = addr;
        cmd.code        = word[CODE_W-1:0];
        if (ctrl == CTRL_SPECIAL) begin
            cmd.load_all_sr = !word[ADDR_LO_POS];
        end else if (!load_n && word[CTRL_LO_POS]) begin
            cmd.load_in = 1'b1;
            cmd.upd_one = 1'b1;
        end else if (ctrl == CTRL_LOAD_IN) begin
            cmd.load_in = 1'b1;
        end else if (ctrl == CTRL_LOAD_UP) begin
            cmd.load_in = 1'b1;
            cmd.upd_all = 1'b1;
        end else begin
            // Update-all ignores the code field entirely
            cmd.upd_all = 1'b1;
            if (addr == ADDR_EDGE_RISE || addr == ADDR_EDGE_FALL) begin
                cmd.set_edge  = 1'b1;
                cmd.edge_rise = (addr == ADDR_EDGE_RISE);
            end
        end
    end
endmodule
`default_nettype wire

// File: design/qdl_loader.sv
// Serial loader and double-buffered code storage for four channels
// Notes on behaviour
// - One 16-bit shift register, in and out
// - Each channel: input register, then converter register
// - Only the shift register is readable
// - Strobe high: double-buffered command-driven loads
// - Strobe low: updates reach output at select rise
// - Strobe low copies all input registers across
// - Word is address, control, then twelve data
// - Address and control choose registers and edge
// - Select high: interface idle, output high
// - Shift input bit on each clock rise
// - Decode and update at select rising edge
// - Data bits ignored for commands without code
// - Load-all writes one code to everything
// - No-operation leaves all registers unchanged
// - Edge change also copies all input registers
// - Control 01 loads; 11 loads and updates all
// - Control 00 load-all or no-op; 10 updates
// - Output lag 16 or 16.5; rising default
// - Strobe low, control low bit: load and update
`timescale 1ns/1ns
`default_nettype none
module qdl_loader
    import qdl_pkg::*;
#(
    parameter int NUM_CH = CHANNELS  // Channel count, fixed by the address
)
(
    input  wire logic        clock,                    // 20 MHz clock
    input  wire logic        srst,                     // Sync reset, high
    input  wire logic        chip_select_n,            // Select pin, low
    input  wire logic        serial_clk,               // Serial clock pin
    input  wire logic        serial_in,                // Serial data pin
    input  wire logic        converter_load_strobe_n,  // Load strobe, low
    output logic             serial_out_level,         // Output level
    output logic             serial_out_oe,            // Output enable
    output logic [CODE_W-1:0] dac_code_a,              // Channel A code
    output logic [CODE_W-1:0] dac_code_b,              // Channel B code
    output logic [CODE_W-1:0] dac_code_c,              // Channel C code
    output logic [CODE_W-1:0] dac_code_d,              // Channel D code
    output logic             edge_rise_mode            // Output edge mode
);
    import qdl_pkg::*;

    // Sampling needs at least two clocks per serial clock period
    initial begin
        if (NUM_CH != CHANNELS) begin
            $error("qdl_loader: channel count must be four");
        end
        if (CLK_KHZ < 2 * SCLK_MAX_KHZ) begin
            $error("qdl_loader: clock too slow for serial rate");
        end
        if (WORD_W != CODE_W + 4) begin
            $error("qdl_loader: word must be code plus four bits");
        end
        if ((1 << CNT_W) <= WORD_W) begin
            $error("qdl_loader: bit counter too narrow");
        end
    end

    typedef struct packed {
        logic                            sclk_d;
        logic                            cs_n_d;
        logic [WORD_W-1:0]               shift;
        logic [NUM_CH-1:0][CODE_W-1:0]   in_reg;
        logic [NUM_CH-1:0][CODE_W-1:0]   dac_reg;
        logic                            edge_rise;
        logic                            out_bit;
        logic [CNT_W-1:0]                bits;
    } qdl_state_t;

    qdl_state_t st_r;
    qdl_state_t st_nxt;
    qdl_pins_t  raw_pins;
    qdl_pins_t  pins;
    qdl_cmd_t   cmd;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_rise;
    logic       cs_fall;

    assign raw_pins = '{cs_n: chip_select_n, sclk: serial_clk,
                        sin: serial_in, load_n: converter_load_strobe_n};

    qdl_sync u_sync (
        .clock    (clock),
        .srst     (srst),
        .pins_in  (raw_pins),
        .pins_out (pins)
    );

    qdl_decode u_decode (
        .word   (st_r.shift),
        .load_n (pins.load_n),
        .cmd    (cmd)
    );

    // Edge detection on synchronised levels only
    assign sclk_rise = pins.sclk && !st_r.sclk_d;
    assign sclk_fall = !pins.sclk && st_r.sclk_d;
    assign cs_rise   = pins.cs_n && !st_r.cs_n_d;
    assign cs_fall   = !pins.cs_n && st_r.cs_n_d;

    // Everything is sampled, so pin edges land two or three clocks late;
    // the trade is a single clock domain with no serial-clocked flops
    // Next-state logic for shifting, decoding and storage
    always_comb begin
        st_nxt        = st_r;
        st_nxt.sclk_d = pins.sclk;
        st_nxt.cs_n_d = pins.cs_n;

        // Shift only while selected; select high freezes the shift register and bit count
        if (!pins.cs_n && sclk_rise) begin
            st_nxt.shift = {st_r.shift[WORD_W-2:0], pins.sin};
            if (st_r.bits != 5'h1F) begin
                st_nxt.bits = st_r.bits + 5'h01;
            end
        end
        if (cs_fall) begin
            st_nxt.bits    = '0;
            st_nxt.out_bit = st_r.shift[WORD_W-1];
        end

        // Output bit follows the MSB on the chosen edge
        if (!pins.cs_n) begin
            if (st_r.edge_rise && sclk_rise) begin
                st_nxt.out_bit = st_r.shift[WORD_W-2];
            end else if (!st_r.edge_rise && sclk_fall) begin
                st_nxt.out_bit = st_r.shift[WORD_W-1];
            end
        end

        // Command takes effect only at select rise, any bit count
        if (cs_rise) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (cmd.load_all_sr) begin
                    st_nxt.in_reg[i]  = cmd.code;
                    st_nxt.dac_reg[i] = cmd.code;
                end else if (cmd.load_in && cmd.chan == 2'(i)) begin
                    st_nxt.in_reg[i] = cmd.code;
                    if (cmd.upd_one) begin
                        st_nxt.dac_reg[i] = cmd.code;
                    end
                end
            end
            if (cmd.upd_all) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    st_nxt.dac_reg[i] = st_nxt.in_reg[i];
                end
            end
            if (cmd.set_edge) begin
                st_nxt.edge_rise = cmd.edge_rise;
            end
        end

        // Applied last so a held strobe also covers a same-cycle load;
        // the strobe is level sensitive, not an edge, by design
        // Strobe low copies every input register; no serial clock used
        if (!pins.load_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                st_nxt.dac_reg[i] = st_nxt.in_reg[i];
            end
        end

        if (srst) begin
            st_nxt.sclk_d    = 1'b0;
            st_nxt.cs_n_d    = 1'b1;
            st_nxt.shift     = SHIFT_RESET;
            st_nxt.in_reg    = {NUM_CH{CODE_RESET}};
            st_nxt.dac_reg   = {NUM_CH{CODE_RESET}};
            st_nxt.edge_rise = EDGE_RESET;
            st_nxt.out_bit   = 1'b1;
            st_nxt.bits      = '0;
        end
    end

    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    // Open-drain style output: released high while deselected
    assign serial_out_oe = !pins.cs_n && !st_r.out_bit;
    assign serial_out_level = 1'b0;
    // Only converter registers leave; input registers have no path out
    assign dac_code_a     = st_r.dac_reg[0];
    assign dac_code_b     = st_r.dac_reg[1];
    assign dac_code_c     = st_r.dac_reg[2];
    assign dac_code_d     = st_r.dac_reg[3];
    assign edge_rise_mode = st_r.edge_rise;

    // Checks
    chk_shift_on_rise: assert property (@(posedge clock) disable iff (srst)
        (!pins.cs_n && sclk_rise) |=> st_r.shift[0] == $past(pins.sin)
    ) else $error("shift did not take input bit");

    chk_idle_no_shift: assert property (@(posedge clock) disable iff (srst)
        (pins.cs_n && !cs_rise) |=> $stable(st_r.shift)
    ) else $error("shift moved while deselected");

    chk_out_released: assert property (@(posedge clock) disable iff (srst)
        pins.cs_n |-> !serial_out_oe
    ) else $error("output driven while deselected");

    chk_dac_hold_shift: assert property (@(posedge clock) disable iff (srst)
        (!cs_rise && pins.load_n && $past(pins.load_n)) |=> $stable(st_r.dac_reg)
    ) else $error("converter changed outside update");

    chk_strobe_copy: assert property (@(posedge clock) disable iff (srst)
        !pins.load_n |=> st_r.dac_reg == st_r.in_reg
    ) else $error("strobe did not copy inputs");

    chk_nop_quiet: assert property (@(posedge clock) disable iff (srst)
        (cs_rise && st_r.shift[13:12] == 2'h0 && st_r.shift[14]
            && pins.load_n)
        |=> $stable(st_r.in_reg) && $stable(st_r.dac_reg)
    ) else $error("no-operation changed registers");

    chk_load_all: assert property (@(posedge clock) disable iff (srst)
        (cs_rise && st_r.shift[14:12] == 3'h0)
        |=> st_r.dac_reg[3] == $past(st_r.shift[11:0])
    ) else $error("load-all did not write code");

    chk_edge_copy: assert property (@(posedge clock) disable iff (srst)
        (cs_rise && st_r.shift[15:12] == 4'hA)
        |=> !st_r.edge_rise && st_r.dac_reg == st_r.in_reg
    ) else $error("edge change missed update");

    chk_load_in_only: assert property (@(posedge clock) disable iff (srst)
        (cs_rise && st_r.shift[13:12] == 2'h1 && pins.load_n
            && $past(pins.load_n))
        |=> $stable(st_r.dac_reg)
    ) else $error("load-only changed converter");

    // Further checks on counting, reset, decoding and output timing
    // Bit counter restarts at every select fall
    chk_count_clear: assert property (@(posedge clock) disable iff (srst)
        cs_fall |=> st_r.bits == '0
    ) else $error("bit counter not cleared");

    // Reset clears shift, input and converter registers and selects rising-edge output
    chk_reset_clear: assert property (@(posedge clock)
        srst |=> st_r.shift == SHIFT_RESET && st_r.edge_rise
            && st_r.dac_reg == '0 && st_r.in_reg == '0
    ) else $error("reset did not clear state");

    // Control 11 with strobe high updates every converter
    chk_load_up_all: assert property (@(posedge clock) disable iff (srst)
        (cs_rise && st_r.shift[13:12] == 2'h3 && pins.load_n)
        |=> st_r.dac_reg == st_r.in_reg
    ) else $error("load-update missed converters");

    // Control 10 copies all input registers across
    chk_update_all: assert property (@(posedge clock) disable iff (srst)
        (cs_rise && st_r.shift[13:12] == 2'h2)
        |=> st_r.dac_reg == st_r.in_reg
    ) else $error("update-all missed converters");

    // Address 11 with control 10 selects rising-edge output
    chk_edge_rise_sel: assert property (@(posedge clock) disable iff (srst)
        (cs_rise && st_r.shift[15:12] == 4'hE)
        |=> st_r.edge_rise
    ) else $error("rising mode not selected");

    // Strobe low: addressed channel updates at once
    chk_transp_one: assert property (@(posedge clock) disable iff (srst)
        (cs_rise && !pins.load_n && st_r.shift[15:12] == 4'hD)
        |=> st_r.dac_reg[3] == $past(st_r.shift[11:0])
    ) else $error("transparent load missed channel");

    // Output edge mode moves only at select rise
    chk_mode_hold: assert property (@(posedge clock) disable iff (srst)
        !cs_rise |=> $stable(st_r.edge_rise)
    ) else $error("edge mode changed outside decode");

    // Rising mode: output takes the next bit at each serial rise
    chk_out_rise: assert property (@(posedge clock) disable iff (srst)
        (!pins.cs_n && st_r.edge_rise && sclk_rise)
        |=> st_r.out_bit == $past(st_r.shift[14])
    ) else $error("rising mode output wrong");

    // Falling mode: output shows the new MSB at each serial fall
    chk_out_fall: assert property (@(posedge clock) disable iff (srst)
        (!pins.cs_n && !st_r.edge_rise && sclk_fall)
        |=> st_r.out_bit == $past(st_r.shift[15])
    ) else $error("falling mode output wrong");

    // Input registers move only on a decoded command
    chk_in_hold: assert property (@(posedge clock) disable iff (srst)
        !cs_rise |=> $stable(st_r.in_reg)
    ) else $error("input register changed outside decode");

    // Select fall presents the old MSB first
    chk_cs_fall_msb: assert property (@(posedge clock) disable iff (srst)
        cs_fall |=> st_r.out_bit == $past(st_r.shift[15])
    ) else $error("select fall did not show MSB");

    // Load-all also writes input register 0 with the code
    chk_ldall_inputs: assert property (@(posedge clock) disable iff (srst)
        (cs_rise && st_r.shift[14:12] == 3'h0)
        |=> st_r.in_reg[0] == $past(st_r.shift[11:0])
    ) else $error("load-all missed input register");

    // Control 01 writes the addressed input register
    chk_load_in_addr: assert property (@(posedge clock) disable iff (srst)
        (cs_rise && st_r.shift[15:12] == 4'h5 && pins.load_n)
        |=> st_r.in_reg[1] == $past(st_r.shift[11:0])
    ) else $error("addressed input not written");
endmodule
`default_nettype wire

// File: sim/qdl_host.sv
// Host serial master model that drives the loader's select, clock and data
`timescale 1ns/1ns
`default_nettype none
module qdl_host (
    input  wire logic clock,    // Bench clock, paces the pins
    input  wire logic sdo_pin,  // Resolved serial output level
    output logic      cs_n,     // Select, active low
    output logic      sclk,     // Serial clock, idle low
    output logic      sin       // Serial data
);
    localparam int HALF = 4;    // 200 ns half period, 2.5 MHz serial clock
    logic [15:0] echo;          // Bits seen on the output pin

    // Idle levels; the serial clock stands still between frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sin  = 1'b0;
        echo = 16'h0000;
    end

    // Waits n bench clocks, then steps just past the edge
    task automatic pace(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Sends the n low bits of w, MSB first, and collects the echo
    task automatic send(input logic [15:0] w, input int n);
        pace(1);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sin = w[i];
            pace(HALF);
            echo = {echo[14:0], sdo_pin};
            sclk = 1'b1;
            pace(HALF);
            sclk = 1'b0;
        end
        pace(HALF);
        cs_n = 1'b1;
        // Released data line must not keep showing the last bit
        sin = ~sin;
        pace(HALF);
    endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the quad converter loader
`timescale 1ns/1ns
`default_nettype none
module tb;
    import qdl_pkg::*;
    logic              clock;
    logic              srst;
    logic              load_n;
    logic              cs_n;
    logic              sclk;
    logic              sin;
    logic              so_o;
    logic              so_oe;
    logic              rise;
    logic [CODE_W-1:0] ca;
    logic [CODE_W-1:0] cb;
    logic [CODE_W-1:0] cc;
    logic [CODE_W-1:0] cd;
    wire logic         sdo_pin;
    int                failures;
    int                tests_run;

    // Open-drain output with a pull-up on the line
    assign sdo_pin = so_oe ? so_o : 1'b1;

    qdl_host host (.clock(clock), .sdo_pin(sdo_pin), .cs_n(cs_n),
                   .sclk(sclk), .sin(sin));

    qdl_loader dut (
        .clock(clock), .srst(srst), .chip_select_n(cs_n),
        .serial_clk(sclk), .serial_in(sin),
        .converter_load_strobe_n(load_n),
        .serial_out_level(so_o), .serial_out_oe(so_oe),
        .dac_code_a(ca), .dac_code_b(cb), .dac_code_c(cc),
        .dac_code_d(cd), .edge_rise_mode(rise)
    );

    // 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic codes(input logic [11:0] a, b, c, d);
        check(16'(ca), 16'(a));
        check(16'(cb), 16'(b));
        check(16'(cc), 16'(c));
        check(16'(cd), 16'(d));
    endtask

    // Full word, then time for the synced select rise to land
    task automatic cmd(input logic [15:0] w);
        host.send(w, 16);
        host.pace(6);
    endtask

    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        finish_test();
    end

    initial begin
        failures = 0;
        tests_run = 0;
        srst = 1'b1;
        load_n = 1'b1;
        repeat (10) @(posedge clock);
        #1;
        srst = 1'b0;
        host.pace(4);
        codes(12'h000, 12'h000, 12'h000, 12'h000);
        check(16'(rise), 16'h0001);
        check(16'(so_oe), 16'h0000);
        $display("done: reset");
        cmd(16'h1123);
        codes(12'h000, 12'h000, 12'h000, 12'h000);
        cmd(16'h2FFF);
        codes(12'h123, 12'h000, 12'h000, 12'h000);
        cmd(16'h1456);
        cmd(16'h7789);
        codes(12'h456, 12'h789, 12'h000, 12'h000);
        $display("done: buffered loads");
        cmd(16'h9ABC);
        codes(12'h456, 12'h789, 12'h000, 12'h000);
        load_n = 1'b0;
        host.pace(4);
        load_n = 1'b1;
        host.pace(2);
        codes(12'h456, 12'h789, 12'hABC, 12'h000);
        $display("done: strobe pulse");
        cmd(16'h8321);
        codes(12'h321, 12'h321, 12'h321, 12'h321);
        cmd(16'hCFFF);
        codes(12'h321, 12'h321, 12'h321, 12'h321);
        $display("done: load all and no-op");
        cmd(16'h1111);
        cmd(16'hA000);
        check(16'(rise), 16'h0000);
        codes(12'h111, 12'h321, 12'h321, 12'h321);
        cmd(16'h4A5A);
        cmd(16'hC3C3);
        check(host.echo, 16'h4A5A);
        check(16'(so_oe), 16'h0000);
        cmd(16'hE000);
        check(16'(rise), 16'h0001);
        cmd(16'h4F0F);
        cmd(16'hC5A5);
        check(host.echo, 16'h4F0F);
        $display("done: output edge and echo");
        load_n = 1'b0;
        cmd(16'hD777);
        codes(12'h111, 12'h321, 12'h321, 12'h777);
        load_n = 1'b1;
        $display("done: transparent strobe");
        cmd(16'h4001);
        host.send(16'h0023, 8);
        host.pace(6);
        codes(12'h123, 12'h123, 12'h123, 12'h123);
        $display("done: short word");
        finish_test();
    end
endmodule
`default_nettype wire
